/* hw/dua_pkg.sv */
// Summary of operation
// R1: Reset pin polarity follows bus-type select
// R2: Reset pulse of 40 ns restores defaults
// R3: Reset holds transmit high, ignores receive
// R4: Low half-duplex strap makes RTS direction output
// R5: Fractional register bit 6 disables auto direction
// R6: Low infrared strap powers up infrared mode
// R7: Fractional register bit 7 disables infrared mode
// R8: Direction goes receive after last stop bit
// R9: Direction goes transmit when byte is loaded
// R10: Without strap, auto direction off after reset
// R11: Direction high means receive, low transmit
// R12: Each channel has 64-byte transmit, receive FIFOs
// R13: Prescaler divides input clock by one or four
// R14: Sampling at 4X, 8X or 16X bit rate
// R15: Channels independent, compatible defaults after reset
// R16: Idle transmit high; infrared encoder idles low
// R17: Mode bits reset from the strap pins
package dua_pkg;
   // Structure
   localparam int CH_N = 2;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 64;
   localparam int FIFO_AW = 6;
   localparam logic [FIFO_AW:0] FIFO_FULL_CNT = 7'h40;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int RST_MIN_NS = 40;
   localparam int RST_MIN_RAW = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int RST_MIN_CYC = (RST_MIN_RAW < 1) ? 1 : RST_MIN_RAW;
   localparam logic [1:0] SETTLE_CNT = 2'h3;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   // Host register addresses
   localparam logic [2:0] ADR_DATA = 3'h0;
   localparam logic [2:0] ADR_DIV_LO = 3'h1;
   localparam logic [2:0] ADR_DIV_HI = 3'h2;
   localparam logic [2:0] ADR_FRAC = 3'h3;
   localparam logic [2:0] ADR_CTRL = 3'h4;
   localparam logic [2:0] ADR_STAT = 3'h5;
   // Fractional divisor register fields
   localparam int FRAC_LSB = 0;
   localparam int FRAC_W = 4;
   localparam int SAMP_LSB = 4;
   localparam int RS485_BIT = 6;
   localparam int IR_BIT = 7;
   // Control register fields
   localparam int PRESC_BIT = 0;
   localparam int RTS_BIT = 1;
   // Status register fields
   localparam int ST_RXAV = 0;
   localparam int ST_TXFE = 1;
   localparam int ST_TEMT = 2;
   localparam int ST_OVR = 3;
   localparam int ST_TXFULL = 4;
   localparam int ST_DIRRX = 5;
   // Reset values
   localparam logic [15:0] DIV_RST = 16'h0001;
   localparam logic [7:0] FRAC_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Sampling modes and their per-bit sub-tick figures
   localparam logic [1:0] SAMP_16X = 2'h0;
   localparam logic [1:0] SAMP_8X = 2'h1;
   localparam logic [1:0] SAMP_4X = 2'h2;
   localparam logic [3:0] LAST_16 = 4'hf;
   localparam logic [3:0] HALF_16 = 4'h7;
   localparam logic [3:0] IRW_16 = 4'h3;
   localparam logic [3:0] LAST_8 = 4'h7;
   localparam logic [3:0] HALF_8 = 4'h3;
   localparam logic [3:0] IRW_8 = 4'h2;
   localparam logic [3:0] LAST_4 = 4'h3;
   localparam logic [3:0] HALF_4 = 4'h1;
   localparam logic [3:0] IRW_4 = 4'h1;
   localparam logic [2:0] BIT_LAST = 3'h7;
   // Serial engine states
   typedef enum logic [1:0] {
      SER_IDLE = 2'h0,
      SER_START = 2'h1,
      SER_DATA = 2'h2,
      SER_STOP = 2'h3
   } dua_ser_state_type;
endpackage : dua_pkg

/* hw/dua_fifo.sv */
`timescale 1ns/1ps
module dua_fifo (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clr,
   // Fill side
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [dua_pkg::DATA_W-1:0] wr_data,
   // Drain side
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [dua_pkg::DATA_W-1:0] rd_data
);
   import dua_pkg::*;

   logic [DATA_W-1:0] mem_q [FIFO_DEPTH]; // Storage, no reset needed
   logic [FIFO_AW-1:0] wp_q, wp_d; // Write pointer
   logic [FIFO_AW-1:0] rp_q, rp_d; // Read pointer
   logic [FIFO_AW:0] cnt_q, cnt_d; // Fill level, one bit wider than pointers
   logic push;
   logic pop;

   assign wr_ready = (cnt_q != FIFO_FULL_CNT); // R12
   assign rd_valid = (cnt_q != '0);
   assign rd_data = mem_q[rp_q];

   // Pointer and level next values
   always_comb begin
      push = wr_valid & wr_ready;
      pop = rd_valid & rd_ready;
      wp_d = push ? wp_q + 6'h01 : wp_q;
      rp_d = pop ? rp_q + 6'h01 : rp_q;
      cnt_d = cnt_q + {6'h00, push} - {6'h00, pop};
      if (clr) begin
         wp_d = '0;
         rp_d = '0;
         cnt_d = '0;
      end
   end

   // Pointer and level registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage write; contents are don't-care while empty
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wp_q] <= wr_data;
      end
   end
endmodule : dua_fifo

/* hw/dua_baud.sv */
`timescale 1ns/1ps
module dua_baud (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clr,
   // Rate setting
   input wire logic [15:0] div,
   input wire logic [dua_pkg::FRAC_W-1:0] frac,
   input wire logic presc4,
   // Sample-rate enable pulse
   output logic samp_tick
);
   import dua_pkg::*;

   logic [1:0] pre_q, pre_d; // Prescaler phase
   logic [16:0] cnt_q, cnt_d; // Divisor counter
   logic [FRAC_W-1:0] acc_q, acc_d; // Fraction accumulator
   logic extra_q, extra_d; // Stretch current period by one
   logic tick_q, tick_d;
   logic pre_en;
   logic [16:0] limit;
   logic [FRAC_W:0] sum;

   assign samp_tick = tick_q;

   // Prescaled divisor with fractional stretch
   always_comb begin
      pre_en = presc4 ? (pre_q == PRESC_LAST) : 1'b1; // R13
      pre_d = pre_q + 2'h1;
      // A zero divisor would stall the channel, so it acts as one
      limit = {1'b0, (div == '0) ? 16'h0001 : div} + {16'h0000, extra_q};
      sum = {1'b0, acc_q} + {1'b0, frac};
      cnt_d = cnt_q;
      acc_d = acc_q;
      extra_d = extra_q;
      tick_d = 1'b0;
      if (pre_en) begin
         if (cnt_q + 17'h00001 >= limit) begin
            cnt_d = '0;
            tick_d = 1'b1;
            acc_d = sum[FRAC_W-1:0];
            extra_d = sum[FRAC_W];
         end else begin
            cnt_d = cnt_q + 17'h00001;
         end
      end
      if (clr) begin
         pre_d = '0;
         cnt_d = '0;
         acc_d = '0;
         extra_d = 1'b0;
         tick_d = 1'b0;
      end
   end

   // Rate registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pre_q <= '0;
         cnt_q <= '0;
         acc_q <= '0;
         extra_q <= 1'b0;
         tick_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         acc_q <= acc_d;
         extra_q <= extra_d;
         tick_q <= tick_d;
      end
   end
endmodule : dua_baud

/* hw/dua_top.sv */
`timescale 1ns/1ps
module dua_top (
   // Clock and system reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Device pins: reset, bus-type select, straps
   input wire logic reset_pin,
   input wire logic bus_sel,
   input wire logic halfduplex_strap_n,
   input wire logic infrared_strap_n,
   // Host strobes, one per channel, same clock
   input wire logic [dua_pkg::CH_N-1:0] hst_wr,
   input wire logic [dua_pkg::CH_N-1:0] hst_rd,
   input wire logic [2:0] hst_addr,
   input wire logic [dua_pkg::DATA_W-1:0] hst_wdata,
   output logic [dua_pkg::CH_N-1:0][dua_pkg::DATA_W-1:0] hst_rdata,
   // Serial pins per channel
   output logic [dua_pkg::CH_N-1:0] txd,
   input wire logic [dua_pkg::CH_N-1:0] rxd,
   output logic [dua_pkg::CH_N-1:0] rts_n
);
   import dua_pkg::*;

   localparam int PIN_N = 4 + CH_N; // Asynchronous pins that are synchronised

   logic [PIN_N-1:0] pin_s1_q; // First stage, read only by second stage
   logic [PIN_N-1:0] pin_s2_q; // Safe to use
   logic [1:0] settle_q, settle_d; // Lets synchronisers fill after power-up
   logic rst_s, sel_s, hd_strap_s, ir_strap_s;
   logic dev_rst; // Reset pin after polarity selection
   logic core_rst; // Reset for all channel state

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {rxd, infrared_strap_n, halfduplex_strap_n, bus_sel, reset_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign rst_s = pin_s2_q[0];
   assign sel_s = pin_s2_q[1];
   assign hd_strap_s = pin_s2_q[2];
   assign ir_strap_s = pin_s2_q[3];
   // High select: active-high reset; low select: active-low reset
   assign dev_rst = sel_s ? rst_s : ~rst_s; // R1
   // Any pulse spanning a clock edge is caught; see RST_MIN_CYC
   assign core_rst = dev_rst | (settle_q != SETTLE_CNT); // R2

   // Settling counter next value
   always_comb begin
      settle_d = (settle_q == SETTLE_CNT) ? settle_q : settle_q + 2'h1;
   end

   // Settling counter register
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         settle_q <= '0;
      end else begin
         settle_q <= settle_d;
      end
   end

   // One identical, independent channel per iteration
   for (genvar g = 0; g < CH_N; g++) begin : g_ch
      logic [15:0] div_q, div_d; // Baud divisor
      logic [7:0] frac_q, frac_d; // Fractional divisor register
      logic [7:0] ctrl_q, ctrl_d; // Prescaler and manual RTS
      logic ovr_q, ovr_d; // Receive overrun, sticky
      logic [7:0] rdata_q, rdata_d; // Host read data
      dua_ser_state_type tx_st_q, tx_st_d;
      logic [7:0] tx_sh_q, tx_sh_d;
      logic [2:0] tx_bit_q, tx_bit_d;
      logic [3:0] tx_sub_q, tx_sub_d;
      logic txd_q, txd_d;
      logic dir_q, dir_d; // High means receive
      logic rts_q, rts_d;
      dua_ser_state_type rx_st_q, rx_st_d;
      logic [7:0] rx_sh_q, rx_sh_d;
      logic [2:0] rx_bit_q, rx_bit_d;
      logic [3:0] rx_sub_q, rx_sub_d;
      logic ir_seen_q, ir_seen_d; // Infrared pulse seen since last sample
      logic tick;
      logic tf_wv, tf_wr, tf_rv, tf_rr;
      logic [7:0] tf_rd;
      logic rf_wv, rf_wr, rf_rv, rf_rr;
      logic [7:0] rf_rd;
      logic [3:0] last_sub, half_sub, ir_w;
      logic ir_on, auto_on, raw, line, samp_pt, tx_val;
      logic [7:0] stat;

      // Transmit FIFO
      dua_fifo u_tx_fifo (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .clr(core_rst),
         .wr_valid(tf_wv),
         .wr_ready(tf_wr),
         .wr_data(hst_wdata),
         .rd_valid(tf_rv),
         .rd_ready(tf_rr),
         .rd_data(tf_rd)
      );

      // Receive FIFO
      dua_fifo u_rx_fifo (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .clr(core_rst),
         .wr_valid(rf_wv),
         .wr_ready(rf_wr),
         .wr_data(rx_sh_q),
         .rd_valid(rf_rv),
         .rd_ready(rf_rr),
         .rd_data(rf_rd)
      );

      // Sample-rate generator
      dua_baud u_baud (
         .sys_clk(sys_clk),
         .nrst(nrst),
         .clr(core_rst),
         .div(div_q),
         .frac(frac_q[FRAC_LSB +: FRAC_W]),
         .presc4(ctrl_q[PRESC_BIT]),
         .samp_tick(tick)
      );

      assign hst_rdata[g] = rdata_q;
      assign txd[g] = txd_q;
      assign rts_n[g] = rts_q;
      assign raw = pin_s2_q[4 + g];
      assign ir_on = frac_q[IR_BIT];
      assign auto_on = frac_q[RS485_BIT];

      // Oversampling figures and received line level
      always_comb begin
         unique case (frac_q[SAMP_LSB +: 2]) // R14
            SAMP_8X: begin
               last_sub = LAST_8;
               half_sub = HALF_8;
               ir_w = IRW_8;
            end
            SAMP_4X: begin
               last_sub = LAST_4;
               half_sub = HALF_4;
               ir_w = IRW_4;
            end
            default: begin
               // Unused code falls back to 16X
               last_sub = LAST_16;
               half_sub = HALF_16;
               ir_w = IRW_16;
            end
         endcase
         // Infrared: a short high pulse anywhere in the bit means zero
         line = ir_on ? ~(raw | ir_seen_q) : raw;
      end

      // Host register access
      always_comb begin
         stat = '0;
         stat[ST_RXAV] = rf_rv;
         stat[ST_TXFE] = ~tf_rv;
         stat[ST_TEMT] = ~tf_rv & (tx_st_q == SER_IDLE);
         stat[ST_OVR] = ovr_q;
         stat[ST_TXFULL] = ~tf_wr;
         stat[ST_DIRRX] = dir_q;
         div_d = div_q;
         frac_d = frac_q;
         ctrl_d = ctrl_q;
         rdata_d = rdata_q;
         // Writes to a full FIFO are dropped
         tf_wv = hst_wr[g] & (hst_addr == ADR_DATA);
         rf_rr = hst_rd[g] & (hst_addr == ADR_DATA);
         if (hst_wr[g]) begin
            unique case (hst_addr)
               ADR_DIV_LO: div_d[7:0] = hst_wdata;
               ADR_DIV_HI: div_d[15:8] = hst_wdata;
               ADR_FRAC: frac_d = hst_wdata; // R5 R7
               ADR_CTRL: ctrl_d = hst_wdata; // R13
               default: ;
            endcase
         end
         if (hst_rd[g]) begin
            unique case (hst_addr)
               ADR_DATA: rdata_d = rf_rv ? rf_rd : 8'h00;
               ADR_DIV_LO: rdata_d = div_q[7:0];
               ADR_DIV_HI: rdata_d = div_q[15:8];
               ADR_FRAC: rdata_d = frac_q;
               ADR_CTRL: rdata_d = ctrl_q;
               ADR_STAT: rdata_d = stat;
               default: rdata_d = 8'h00;
            endcase
         end
         if (core_rst) begin
            div_d = DIV_RST;
            frac_d = FRAC_RST;
            // Straps are active low and reload on every reset
            frac_d[RS485_BIT] = ~hd_strap_s; // R4 R10 R17
            frac_d[IR_BIT] = ~ir_strap_s; // R6 R17
            ctrl_d = CTRL_RST; // R15
            rdata_d = 8'h00;
         end
      end

      // Transmitter and direction control
      always_comb begin
         tx_st_d = tx_st_q;
         tx_sh_d = tx_sh_q;
         tx_bit_d = tx_bit_q;
         tx_sub_d = tx_sub_q;
         dir_d = dir_q;
         tf_rr = tick & (tx_st_q == SER_IDLE);
         if (tick) begin
            if (tx_st_q == SER_IDLE) begin
               if (tf_rv) begin
                  tx_sh_d = tf_rd;
                  tx_st_d = SER_START;
                  tx_sub_d = '0;
                  tx_bit_d = '0;
               end
            end else if (tx_sub_q != last_sub) begin
               tx_sub_d = tx_sub_q + 4'h1;
            end else begin
               tx_sub_d = '0;
               unique case (tx_st_q)
                  SER_START: tx_st_d = SER_DATA;
                  SER_DATA: begin
                     tx_sh_d = {1'b1, tx_sh_q[7:1]};
                     tx_bit_d = tx_bit_q + 3'h1;
                     if (tx_bit_q == BIT_LAST) begin
                        tx_st_d = SER_STOP;
                     end
                  end
                  default: begin
                     tx_st_d = SER_IDLE;
                     // Stop bit fully sent and nothing queued
                     if (!tf_rv) begin
                        dir_d = 1'b1; // R8
                     end
                  end
               endcase
            end
         end
         // A byte loaded now wins over the release above
         if (tf_wv & tf_wr) begin
            dir_d = 1'b0; // R9
         end
         unique case (tx_st_q)
            SER_START: tx_val = 1'b0;
            SER_DATA: tx_val = tx_sh_q[0];
            default: tx_val = 1'b1;
         endcase
         // Encoder sends a short high pulse per zero, else idles low
         if (ir_on) begin
            txd_d = ~tx_val & (tx_sub_q < ir_w); // R16
         end else begin
            txd_d = tx_val; // R16
         end
         // Direction drives RTS only in auto mode; manual RTS is low-true
         rts_d = auto_on ? dir_q : ~ctrl_q[RTS_BIT]; // R11
         if (core_rst) begin
            tx_st_d = SER_IDLE;
            tx_sub_d = '0;
            tx_bit_d = '0;
            tx_sh_d = '0;
            txd_d = 1'b1; // R3
            dir_d = 1'b1;
            rts_d = 1'b1;
            tf_rr = 1'b0;
         end
      end

      // Receiver
      always_comb begin
         rx_st_d = rx_st_q;
         rx_sh_d = rx_sh_q;
         rx_bit_d = rx_bit_q;
         rx_sub_d = rx_sub_q;
         rf_wv = 1'b0;
         ovr_d = ovr_q;
         samp_pt = tick & (((rx_st_q == SER_START) & (rx_sub_q == half_sub))
                   | ((rx_st_q != SER_IDLE) & (rx_st_q != SER_START)
                   & (rx_sub_q == last_sub)));
         if (tick) begin
            if (rx_st_q == SER_IDLE) begin
               if (!line) begin
                  rx_st_d = SER_START;
                  rx_sub_d = '0;
               end
            end else if (!samp_pt) begin
               rx_sub_d = rx_sub_q + 4'h1;
            end else begin
               rx_sub_d = '0;
               unique case (rx_st_q)
                  SER_START: begin
                     // Glitch shorter than half a bit is dropped
                     rx_st_d = line ? SER_IDLE : SER_DATA;
                     rx_bit_d = '0;
                  end
                  SER_DATA: begin
                     rx_sh_d = {line, rx_sh_q[7:1]};
                     rx_bit_d = rx_bit_q + 3'h1;
                     if (rx_bit_q == BIT_LAST) begin
                        rx_st_d = SER_STOP;
                     end
                  end
                  default: begin
                     rx_st_d = SER_IDLE;
                     rf_wv = line;
                     if (line & ~rf_wr) begin
                        ovr_d = 1'b1;
                     end
                  end
               endcase
            end
         end
         // Status read clears overrun unless a new one lands now
         if (hst_rd[g] & (hst_addr == ADR_STAT) & ~(rf_wv & ~rf_wr)) begin
            ovr_d = 1'b0;
         end
         ir_seen_d = ir_on & (raw | ir_seen_q) & ~samp_pt;
         if (core_rst) begin
            // Line is ignored while reset is held
            rx_st_d = SER_IDLE; // R3
            rx_sh_d = '0;
            rx_bit_d = '0;
            rx_sub_d = '0;
            rf_wv = 1'b0;
            ovr_d = 1'b0;
            ir_seen_d = 1'b0;
         end
      end

      // Channel registers
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            div_q <= DIV_RST;
            frac_q <= FRAC_RST;
            ctrl_q <= CTRL_RST;
            ovr_q <= 1'b0;
            rdata_q <= 8'h00;
            tx_st_q <= SER_IDLE;
            tx_sh_q <= '0;
            tx_bit_q <= '0;
            tx_sub_q <= '0;
            txd_q <= 1'b1;
            dir_q <= 1'b1;
            rts_q <= 1'b1;
            rx_st_q <= SER_IDLE;
            rx_sh_q <= '0;
            rx_bit_q <= '0;
            rx_sub_q <= '0;
            ir_seen_q <= 1'b0;
         end else begin
            div_q <= div_d;
            frac_q <= frac_d;
            ctrl_q <= ctrl_d;
            ovr_q <= ovr_d;
            rdata_q <= rdata_d;
            tx_st_q <= tx_st_d;
            tx_sh_q <= tx_sh_d;
            tx_bit_q <= tx_bit_d;
            tx_sub_q <= tx_sub_d;
            txd_q <= txd_d;
            dir_q <= dir_d;
            rts_q <= rts_d;
            rx_st_q <= rx_st_d;
            rx_sh_q <= rx_sh_d;
            rx_bit_q <= rx_bit_d;
            rx_sub_q <= rx_sub_d;
            ir_seen_q <= ir_seen_d;
         end
      end
   end
endmodule : dua_top

/* test/dua_xcvr_model.sv */
`timescale 1ns/1ps
module dua_xcvr_model #(
   parameter int BIT_NS = 1600
) (
   // Device side
   input wire logic txd,
   input wire logic rts_n,
   output logic rxd
);
   logic line = 1'b1; // Remote idles at mark
   logic bus; // Shared pair level
   // Device drives pair when transmitting
   assign bus = rts_n ? line : txd;
   // Receiver off while transmitting: mark
   assign rxd = rts_n ? bus : 1'b1;
   // Remote sends one 8N1 frame, LSB first
   task automatic send(input logic [7:0] b);
      line = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++) begin
         line = b[i];
         #(BIT_NS);
      end
      line = 1'b1;
      #(BIT_NS);
   endtask : send
endmodule : dua_xcvr_model

/* test/dua_top_monitor.sv */
`timescale 1ns/1ps
module dua_top_monitor (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reset_pin,
   input wire logic bus_sel,
   // Host strobes and read data
   input wire logic [dua_pkg::CH_N-1:0] hst_wr,
   input wire logic [dua_pkg::CH_N-1:0] hst_rd,
   input wire logic [dua_pkg::CH_N-1:0][dua_pkg::DATA_W-1:0] hst_rdata,
   // Serial pins
   input wire logic [dua_pkg::CH_N-1:0] txd,
   input wire logic [dua_pkg::CH_N-1:0] rts_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // System reset holds outputs at default
   property p_sys_rst;
      disable iff (1'b0) !nrst |-> txd == '1 && rts_n == '1 && hst_rdata == '0;
   endproperty
   a_sys_rst: assert property (p_sys_rst) else $error("outputs not reset");
   // Pin active high in one mode
   property p_rst_hi;
      (bus_sel && reset_pin) [*6] |-> txd == '1 && rts_n == '1;
   endproperty
   a_rst_hi: assert property (p_rst_hi) else $error("high reset ignored");
   // Pin active low in other mode
   property p_rst_lo;
      (!bus_sel && !reset_pin) [*6] |-> txd == '1 && rts_n == '1;
   endproperty
   a_rst_lo: assert property (p_rst_lo) else $error("low reset ignored");
   // Transmit state follows a load two edges later
   property p_dir0;
      $fell(rts_n[0]) |-> $past(hst_wr[0], 2);
   endproperty
   a_dir0: assert property (p_dir0) else $error("ch0 dir fell");
   property p_dir1;
      $fell(rts_n[1]) |-> $past(hst_wr[1], 2);
   endproperty
   a_dir1: assert property (p_dir1) else $error("ch1 dir fell");
   // Read data moves only on read or reset
   property p_rdat0;
      !$stable(hst_rdata[0]) |-> $past(hst_rd[0]) || hst_rdata[0] == '0;
   endproperty
   a_rdat0: assert property (p_rdat0) else $error("ch0 rdata moved");
   property p_rdat1;
      !$stable(hst_rdata[1]) |-> $past(hst_rd[1]) || hst_rdata[1] == '0;
   endproperty
   a_rdat1: assert property (p_rdat1) else $error("ch1 rdata moved");
   // No low run under three cycles
   property p_txlow;
      $fell(txd[0]) |-> !txd[0] [*3];
   endproperty
   a_txlow: assert property (p_txlow) else $error("short low on txd");
   c_dir: cover property ($fell(rts_n[0]));
   c_tx: cover property ($fell(txd[0]));
   c_lo: cover property ((!bus_sel && !reset_pin) [*6]);
endmodule : dua_top_monitor
bind dua_top dua_top_monitor mon (.sys_clk(sys_clk), .nrst(nrst), .reset_pin(reset_pin),
   .bus_sel(bus_sel), .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_rdata(hst_rdata),
   .txd(txd), .rts_n(rts_n));

/* test/dua_top_test.sv */
`timescale 1ns/1ps
module dua_top_test;
   import dua_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b1, reset_pin = 1'b0, bus_sel = 1'b1;
   logic halfduplex_strap_n = 1'b1, infrared_strap_n = 1'b1;
   logic [CH_N-1:0] hst_wr = '0, hst_rd = '0;
   logic [2:0] hst_addr = '0;
   logic [DATA_W-1:0] hst_wdata = '0;
   logic [CH_N-1:0][DATA_W-1:0] hst_rdata;
   logic [CH_N-1:0] txd, rxd, rts_n;
   int mismatches = 0, n_tests = 0, cyc = 0, n;
   always #50 sys_clk = ~sys_clk;
   dua_top DUT (.sys_clk(sys_clk), .nrst(nrst), .reset_pin(reset_pin), .bus_sel(bus_sel),
      .halfduplex_strap_n(halfduplex_strap_n), .infrared_strap_n(infrared_strap_n),
      .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_addr(hst_addr), .hst_wdata(hst_wdata),
      .hst_rdata(hst_rdata), .txd(txd), .rxd(rxd), .rts_n(rts_n));
   dua_xcvr_model xcvr (.txd(txd[0]), .rts_n(rts_n[0]), .rxd(rxd[0]));
   assign rxd[1] = 1'b1; // Idle line
   task summarize;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         summarize();
      end
   end
   task automatic chk(input logic ok, string m);
      n_tests++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask : chk
   // Inputs move just after a rising edge
   task automatic cyc_n(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : cyc_n
   task automatic wr(input logic [1:0] m, logic [2:0] a, logic [7:0] d);
      cyc_n(1);
      hst_wr = m;
      hst_addr = a;
      hst_wdata = d;
      cyc_n(1);
      hst_wr = '0;
   endtask : wr
   task automatic rd(input int c, logic [2:0] a, logic [7:0] k, e);
      cyc_n(1);
      hst_rd[c] = 1'b1;
      hst_addr = a;
      cyc_n(1);
      hst_rd = '0;
      chk((hst_rdata[c] & k) === e, "read value");
   endtask : rd
   // Wait for a txd level, then time it
   task automatic wt(input int c, logic v, int lim);
      n = 0;
      while (txd[c] !== v && n < lim) begin
         cyc_n(1);
         n++;
      end
      n = 0;
      while (txd[c] === v && n < 900) begin
         cyc_n(1);
         n++;
      end
   endtask : wt
   // Pin pulse at the active level
   task automatic rst_dev(input int k);
      reset_pin = bus_sel;
      cyc_n(k);
      reset_pin = !bus_sel;
      cyc_n(10);
   endtask : rst_dev
   task t_defaults;
      rd(0, ADR_FRAC, 8'hff, 8'h00);
      rd(1, ADR_FRAC, 8'hff, 8'h00);
      rd(1, ADR_DIV_LO, 8'hff, 8'h01);
      rd(0, ADR_STAT, 8'h06, 8'h06);
      chk(txd === 2'b11 && rts_n === 2'b11, "idle pins");
      $display("defaults done");
   endtask : t_defaults
   // All-ones byte: only start bit is low
   task t_rates;
      for (int i = 0; i < 3; i++) begin
         wr(2'b01, ADR_FRAC, 8'(i << 4));
         wr(2'b01, ADR_DATA, 8'hff);
         wt(0, 1'b0, 300);
         chk(n == (16 >> i), "start bit width");
         cyc_n(200);
      end
      wr(2'b01, ADR_CTRL, 8'h01);
      wr(2'b01, ADR_FRAC, 8'h00);
      wr(2'b01, ADR_DATA, 8'hff);
      wt(0, 1'b0, 900);
      chk(n == 64, "prescaled width");
      cyc_n(700);
      wr(2'b01, ADR_CTRL, 8'h00);
      $display("rates done");
   endtask : t_rates
   task t_dir;
      halfduplex_strap_n = 1'b0;
      rst_dev(2);
      rd(0, ADR_FRAC, 8'hff, 8'h40);
      rd(1, ADR_FRAC, 8'hff, 8'h40);
      wr(2'b01, ADR_DATA, 8'h00);
      cyc_n(1);
      chk(rts_n === 2'b10, "direction to transmit");
      n = 0;
      while (rts_n[0] !== 1'b1 && n < 400) begin
         cyc_n(1);
         n++;
      end
      chk(n > 150 && n < 180 && txd[0] === 1'b1, "direction to receive");
      xcvr.send(8'ha5);
      cyc_n(10);
      rd(0, ADR_DATA, 8'hff, 8'ha5);
      wr(2'b10, ADR_DATA, 8'h00);
      cyc_n(1);
      chk(rts_n === 2'b01, "channels independent");
      cyc_n(200);
      wr(2'b11, ADR_FRAC, 8'h00);
      wr(2'b01, ADR_DATA, 8'h00);
      cyc_n(2);
      chk(rts_n === 2'b11, "auto direction off");
      cyc_n(200);
      halfduplex_strap_n = 1'b1;
      rst_dev(2);
      $display("direction done");
   endtask : t_dir
   task t_ir;
      infrared_strap_n = 1'b0;
      rst_dev(2);
      rd(0, ADR_FRAC, 8'hff, 8'h80);
      chk(txd === 2'b00, "infrared idle low");
      wr(2'b01, ADR_DATA, 8'h00);
      wt(0, 1'b1, 300);
      chk(n == 3, "ir pulse width");
      cyc_n(200);
      wr(2'b11, ADR_FRAC, 8'h00);
      cyc_n(3);
      chk(txd === 2'b11, "normal idle high");
      infrared_strap_n = 1'b1;
      rst_dev(2);
      $display("infrared done");
   endtask : t_ir
   task t_reset;
      wr(2'b11, ADR_DIV_LO, 8'h05);
      wr(2'b01, ADR_DATA, 8'h00);
      cyc_n(60);
      reset_pin = 1'b1;
      xcvr.send(8'h3c);
      chk(txd === 2'b11 && rts_n === 2'b11, "pins held in reset");
      reset_pin = 1'b0;
      cyc_n(10);
      rd(0, ADR_STAT, 8'h01, 8'h00);
      rd(1, ADR_DIV_LO, 8'hff, 8'h01);
      bus_sel = 1'b0;
      reset_pin = 1'b1;
      cyc_n(10);
      wr(2'b01, ADR_DIV_LO, 8'h05);
      rd(0, ADR_DIV_LO, 8'hff, 8'h05);
      rst_dev(7);
      rd(0, ADR_DIV_LO, 8'hff, 8'h01);
      bus_sel = 1'b1;
      reset_pin = 1'b0;
      cyc_n(10);
      $display("reset done");
   endtask : t_reset
   // Slow rate lets the queue fill
   task t_fifo;
      wr(2'b10, ADR_DIV_HI, 8'hff);
      repeat (63) wr(2'b10, ADR_DATA, 8'h11);
      rd(1, ADR_STAT, 8'h10, 8'h00);
      repeat (3) wr(2'b10, ADR_DATA, 8'h11);
      rd(1, ADR_STAT, 8'h10, 8'h10);
      rst_dev(2);
      $display("fifo done");
   endtask : t_fifo
   initial begin
      #1 nrst = 1'b0;
      cyc_n(6);
      nrst = 1'b1;
      cyc_n(10);
      t_defaults();
      t_rates();
      t_dir();
      t_ir();
      t_reset();
      t_fifo();
      summarize();
   end
endmodule : dua_top_test
